// ===== logic/csf_consts.svh
// Overview of operation
// [RULE1] Bits 15 to 9 of the flags word read as zero and ignore writes.
// [RULE2] Half carry is the carry out of bit 3 (byte) or bit 7 (word).
// [RULE3] Bits 7 to 5 hold the low three priority bits; 111 blocks user IRQs.
// [RULE4] Top priority bit comes from core control; set, it blocks user IRQs.
// [RULE5] With nesting off set, software cannot change the priority bits.
// [RULE6] Bit 4 shows a running repeat loop, is read-only and resets to zero.
// [RULE7] Negative is set for a negative result and cleared otherwise.
// [RULE8] Overflow is set on a signed overflow and cleared otherwise.
// [RULE9] Zero is cleared by a non-zero result and otherwise stays set; the code sets it on a zero result unless zero_sticky.
// [RULE10] Carry is set on a carry out of the result's top bit, else cleared.
// [RULE11] All implemented bits reset to zero; loop bit read-only, others R/W.
// [RULE12] Sign and carry positions are bit 7 for bytes and bit 15 for words.
// [RULE13] Only chosen flags change; software writes beat same-cycle updates.
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// Register offsets
`define CSF_ADDR_FLAGS 4'h0
`define CSF_ADDR_CTRL 4'h1
`define CSF_ADDR_EVT_STAT 4'h2
`define CSF_ADDR_EVT_CLR 4'h3
`define CSF_ADDR_EVT_EN 4'h4

// Flags word fields
`define CSF_BIT_HC 8
`define CSF_BIT_IPL_HI 7
`define CSF_BIT_IPL_LO 5
`define CSF_BIT_LOOP 4
`define CSF_BIT_NEG 3
`define CSF_BIT_OVF 2
`define CSF_BIT_ZERO 1
`define CSF_BIT_CARRY 0
`define CSF_UNIMPL_HI 15
`define CSF_UNIMPL_LO 9
`define CSF_UNIMPL_ZERO 7'h00
`define CSF_FLAGS_RST 16'h0000
`define CSF_IPL_RST 3'h0
`define CSF_IPL_ALL_OFF 3'h7
`define CSF_IPL_TOP_ON 4'h8

// Control word fields
`define CSF_CTRL_IPL_TOP 3
`define CSF_CTRL_NEST_OFF 15

// Event bits
`define CSF_EVT_OVF 0
`define CSF_EVT_LOOP_END 1
`define CSF_EVT_USR_OFF 2
`define CSF_EVT_RST 3'h0

// Arithmetic positions
`define CSF_HC_BYTE 4
`define CSF_MSB_BYTE 7
`define CSF_MSB_WORD 15
`define CSF_BYTE_HI 15
`define CSF_BYTE_LO 8
`define CSF_ZERO_BYTE 8'h00
`define CSF_ZERO_WORD 16'h0000

`endif

// ===== logic/csf_pkg.sv
package csf_pkg;

	// One bit per arithmetic flag
	typedef struct packed {
		logic hc;
		logic neg;
		logic ovf;
		logic zero;
		logic carry;
	} csf_flag_set_t;

	// Flag-affecting operation from the ALU
	typedef struct packed {
		logic valid;
		logic byte_op;
		logic zero_sticky;
		csf_flag_set_t affect;
		logic carry_in;
		logic [15:0] op_a;
		logic [15:0] op_b;
	} csf_alu_req_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} csf_bus_req_t;

	// Repeat loop tracking
	typedef enum logic {
		LOOP_IDLE,
		LOOP_RUN
	} csf_loop_t;

endpackage

// ===== logic/csf_flag_calc.sv
`timescale 1ns/1ps
`include "csf_consts.svh"

module csf_flag_calc (
	// Operation in
	input wire csf_pkg::csf_alu_req_t req,
	// Flags and result out
	output csf_pkg::csf_flag_set_t flags,
	output logic [15:0] result
);
	import csf_pkg::*;

	// Partial sums for nibble, byte and word
	wire [4:0] sum_nib = 5'(req.op_a[3:0]) + 5'(req.op_b[3:0])
		+ 5'(req.carry_in);
	wire [8:0] sum_byt = 9'(req.op_a[7:0]) + 9'(req.op_b[7:0])
		+ 9'(req.carry_in);
	wire [16:0] sum_wrd = 17'(req.op_a) + 17'(req.op_b)
		+ 17'(req.carry_in);

	// Sign positions by operand width
	wire a_msb = req.byte_op ? req.op_a[`CSF_MSB_BYTE] :
		req.op_a[`CSF_MSB_WORD]; // see [RULE12]
	wire b_msb = req.byte_op ? req.op_b[`CSF_MSB_BYTE] :
		req.op_b[`CSF_MSB_WORD];
	wire r_msb = req.byte_op ? sum_wrd[`CSF_MSB_BYTE] :
		sum_wrd[`CSF_MSB_WORD];

	// Flag values
	assign flags.hc = req.byte_op ? sum_nib[`CSF_HC_BYTE] :
		sum_byt[`CSF_MSB_BYTE + 1]; // see [RULE2]
	assign flags.neg = r_msb; // see [RULE7]
	assign flags.ovf = (a_msb == b_msb) && (r_msb != a_msb); // see [RULE8]
	assign flags.zero = req.byte_op ?
		(sum_wrd[7:0] == `CSF_ZERO_BYTE) :
		(sum_wrd[15:0] == `CSF_ZERO_WORD);
	assign flags.carry = req.byte_op ? sum_byt[`CSF_MSB_BYTE + 1] :
		sum_wrd[`CSF_MSB_WORD + 1]; // see [RULE10]

	// Byte results keep the upper byte of operand A
	assign result = req.byte_op ?
		{req.op_a[`CSF_BYTE_HI:`CSF_BYTE_LO], sum_wrd[7:0]} :
		sum_wrd[15:0];

endmodule

// ===== logic/csf_status_reg.sv
`timescale 1ns/1ps
`include "csf_consts.svh"

module csf_status_reg #(
	parameter int DATA_W = 16,
	parameter int EVT_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire csf_pkg::csf_bus_req_t bus,
	output logic [DATA_W-1:0] rd_data,
	// ALU side
	input wire csf_pkg::csf_alu_req_t alu_req,
	output logic [DATA_W-1:0] alu_result,
	// Loop sequencer
	input wire logic loop_start,
	input wire logic loop_done,
	// Status toward the core
	output logic [DATA_W-1:0] flags_word,
	output logic [3:0] eff_priority,
	output logic user_irq_off,
	// Interrupt
	output logic irq
);
	import csf_pkg::*;

	// Flag state
	logic hc_r, neg_r, ovf_r, zero_r, carry_r;
	logic hc_nxt, neg_nxt, ovf_nxt, zero_nxt, carry_nxt;
	logic [2:0] ipl_r, ipl_nxt;
	csf_loop_t loop_r, loop_nxt;

	// Control state
	logic ipl_top_r, ipl_top_nxt;
	logic nest_off_r, nest_off_nxt;

	// Event state
	logic [EVT_W-1:0] evt_stat_r, evt_stat_nxt;
	logic [EVT_W-1:0] evt_en_r, evt_en_nxt;
	logic [EVT_W-1:0] evt_now, evt_clr;
	logic usr_off_r, usr_off_nxt;

	// Read and result registers
	logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
	logic [DATA_W-1:0] alu_result_r, alu_result_nxt;

	// Flag computation
	csf_flag_set_t calc_flags;
	logic [15:0] calc_res;

	csf_flag_calc u_calc (
		.req(alu_req),
		.flags(calc_flags),
		.result(calc_res)
	);

	// Address decode
	wire hit_flags = bus.addr == `CSF_ADDR_FLAGS;
	wire hit_ctrl = bus.addr == `CSF_ADDR_CTRL;
	wire hit_stat = bus.addr == `CSF_ADDR_EVT_STAT;
	wire hit_clr = bus.addr == `CSF_ADDR_EVT_CLR;
	wire hit_en = bus.addr == `CSF_ADDR_EVT_EN;
	wire wr_flags = bus.wr && hit_flags;
	wire wr_ctrl = bus.wr && hit_ctrl;
	wire wr_clr = bus.wr && hit_clr;
	wire wr_en = bus.wr && hit_en;

	// ALU update qualifiers per flag
	wire upd_hc = alu_req.valid && alu_req.affect.hc;
	wire upd_neg = alu_req.valid && alu_req.affect.neg;
	wire upd_ovf = alu_req.valid && alu_req.affect.ovf;
	wire upd_zero = alu_req.valid && alu_req.affect.zero;
	wire upd_carry = alu_req.valid && alu_req.affect.carry;

	// Zero flag keeps its set state for sticky operations
	wire zero_alu = calc_flags.zero ?
		(alu_req.zero_sticky ? zero_r : 1'b1) : 1'b0; // see [RULE9]

	// Software write first, then ALU update, else hold
	assign hc_nxt = wr_flags ? bus.wdata[`CSF_BIT_HC] :
		upd_hc ? calc_flags.hc : hc_r; // see [RULE2] see [RULE13]
	assign neg_nxt = wr_flags ? bus.wdata[`CSF_BIT_NEG] :
		upd_neg ? calc_flags.neg : neg_r; // see [RULE7]
	assign ovf_nxt = wr_flags ? bus.wdata[`CSF_BIT_OVF] :
		upd_ovf ? calc_flags.ovf : ovf_r; // see [RULE8]
	assign zero_nxt = wr_flags ? bus.wdata[`CSF_BIT_ZERO] :
		upd_zero ? zero_alu : zero_r; // see [RULE9]
	assign carry_nxt = wr_flags ? bus.wdata[`CSF_BIT_CARRY] :
		upd_carry ? calc_flags.carry : carry_r; // see [RULE10]

	// Priority bits locked while nesting is off
	assign ipl_nxt = (wr_flags && !nest_off_r) ?
		bus.wdata[`CSF_BIT_IPL_HI:`CSF_BIT_IPL_LO] : ipl_r; // see [RULE5]

	// Control word fields
	assign ipl_top_nxt = wr_ctrl ? bus.wdata[`CSF_CTRL_IPL_TOP] :
		ipl_top_r;
	assign nest_off_nxt = wr_ctrl ? bus.wdata[`CSF_CTRL_NEST_OFF] :
		nest_off_r;

	// Repeat loop tracking, not reachable by software
	always_comb begin
		loop_nxt = loop_r;
		case (loop_r)
			LOOP_IDLE: begin
				if (loop_start) begin
					loop_nxt = LOOP_RUN; // see [RULE6]
				end
			end
			LOOP_RUN: begin
				if (loop_done) begin
					loop_nxt = LOOP_IDLE;
				end
			end
			default: begin
				loop_nxt = LOOP_IDLE;
			end
		endcase
	end

	// Effective priority and user interrupt block
	assign eff_priority = {ipl_top_r, ipl_r}; // see [RULE4]
	assign user_irq_off = ipl_top_r ||
		(ipl_r == `CSF_IPL_ALL_OFF); // see [RULE3] see [RULE4]
	assign usr_off_nxt = ipl_top_nxt || (ipl_nxt == `CSF_IPL_ALL_OFF);

	// Events: signed overflow, loop end, user interrupts blocked
	assign evt_now[`CSF_EVT_OVF] = upd_ovf && calc_flags.ovf && !wr_flags;
	assign evt_now[`CSF_EVT_LOOP_END] = (loop_r == LOOP_RUN) && loop_done;
	assign evt_now[`CSF_EVT_USR_OFF] = usr_off_nxt && !usr_off_r;

	// Sticky status; a new event wins over a same-cycle clear
	assign evt_clr = wr_clr ? bus.wdata[EVT_W-1:0] : `CSF_EVT_RST;
	assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_now;
	assign evt_en_nxt = wr_en ? bus.wdata[EVT_W-1:0] : evt_en_r;
	assign irq = |(evt_stat_r & evt_en_r);

	// Assembled flags word with unimplemented bits at zero
	assign flags_word = {`CSF_UNIMPL_ZERO, hc_r, ipl_r,
		loop_r == LOOP_RUN, neg_r, ovf_r, zero_r, carry_r}; // see [RULE1]

	// Control word image
	logic [DATA_W-1:0] ctrl_word;
	always_comb begin
		ctrl_word = '0;
		ctrl_word[`CSF_CTRL_IPL_TOP] = ipl_top_r;
		ctrl_word[`CSF_CTRL_NEST_OFF] = nest_off_r;
	end

	// Read selection; unmapped and write-only offsets read zero
	wire [DATA_W-1:0] rd_sel =
		hit_flags ? flags_word :
		hit_ctrl ? ctrl_word :
		hit_stat ? DATA_W'(evt_stat_r) :
		hit_en ? DATA_W'(evt_en_r) : '0;
	assign rd_data_nxt = bus.rd ? rd_sel : '0;
	assign rd_data = rd_data_r;

	// Result capture
	assign alu_result_nxt = alu_req.valid ? calc_res : alu_result_r;
	assign alu_result = alu_result_r;

	// Flag registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hc_r <= 1'b0; // see [RULE11]
			neg_r <= 1'b0;
			ovf_r <= 1'b0;
			zero_r <= 1'b0;
			carry_r <= 1'b0;
			ipl_r <= `CSF_IPL_RST;
			loop_r <= LOOP_IDLE;
		end else begin
			hc_r <= hc_nxt;
			neg_r <= neg_nxt;
			ovf_r <= ovf_nxt;
			zero_r <= zero_nxt;
			carry_r <= carry_nxt;
			ipl_r <= ipl_nxt;
			loop_r <= loop_nxt;
		end
	end

	// Control and event registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ipl_top_r <= 1'b0;
			nest_off_r <= 1'b0;
			usr_off_r <= 1'b0;
			evt_stat_r <= `CSF_EVT_RST;
			evt_en_r <= `CSF_EVT_RST;
		end else begin
			ipl_top_r <= ipl_top_nxt;
			nest_off_r <= nest_off_nxt;
			usr_off_r <= usr_off_nxt;
			evt_stat_r <= evt_stat_nxt;
			evt_en_r <= evt_en_nxt;
		end
	end

	// Read data and result registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_data_r <= '0;
			alu_result_r <= '0;
		end else begin
			rd_data_r <= rd_data_nxt;
			alu_result_r <= alu_result_nxt;
		end
	end

	// Upper bits of a flags read are zero even after writing ones
	a_unimpl_read_zero: assert property ( // see [RULE1]
		@(posedge clk) disable iff (!rst_b)
		bus.rd && hit_flags |=>
		rd_data[`CSF_UNIMPL_HI:`CSF_UNIMPL_LO] == `CSF_UNIMPL_ZERO)
		else $error("unimplemented flag bits read nonzero");

	// Half carry follows the operation when software is quiet
	a_half_carry_upd: assert property ( // see [RULE2]
		@(posedge clk) disable iff (!rst_b)
		upd_hc && !wr_flags |=> hc_r == $past(calc_flags.hc))
		else $error("half carry not taken from operation");

	// Priority bits take a permitted write and block at all ones
	a_ipl_write_taken: assert property ( // see [RULE3]
		@(posedge clk) disable iff (!rst_b)
		wr_flags && !nest_off_r && !ipl_top_r &&
		bus.wdata[`CSF_BIT_IPL_HI:`CSF_BIT_IPL_LO] == `CSF_IPL_ALL_OFF
		|=> flags_word[`CSF_BIT_IPL_HI:`CSF_BIT_IPL_LO] ==
		`CSF_IPL_ALL_OFF && user_irq_off)
		else $error("priority write lost or not blocking");

	// Top priority bit lifts level to 8..15 and blocks user IRQs
	a_top_bit_blocks: assert property ( // see [RULE4]
		@(posedge clk) disable iff (!rst_b)
		wr_ctrl && bus.wdata[`CSF_CTRL_IPL_TOP] |=>
		eff_priority >= `CSF_IPL_TOP_ON && user_irq_off)
		else $error("top priority bit not effective");

	// Nesting off freezes the priority bits for two cycles
	a_nest_lock_hold: assert property ( // see [RULE5]
		@(posedge clk) disable iff (!rst_b)
		wr_flags && nest_off_r && !wr_ctrl |=>
		$stable(ipl_r) ##1 (ipl_r == $past(ipl_r, 2) || $past(wr_flags)))
		else $error("priority changed while locked");

	// Loop bit rises the cycle after a loop starts
	a_loop_flag_seq: assert property ( // see [RULE6]
		@(posedge clk) disable iff (!rst_b)
		loop_r == LOOP_IDLE && loop_start |=>
		flags_word[`CSF_BIT_LOOP])
		else $error("loop bit not set on loop start");

	// Software cannot set the loop bit while no loop runs
	a_loop_sw_ro: assert property ( // see [RULE6]
		@(posedge clk) disable iff (!rst_b)
		loop_r == LOOP_IDLE && !loop_start && wr_flags |=>
		!flags_word[`CSF_BIT_LOOP])
		else $error("loop bit written by software");

	// Negative and overflow from the bit 7 sign bit of byte operations
	a_neg_ovf_sign: assert property ( // see [RULE7] see [RULE8] see [RULE12]
		@(posedge clk) disable iff (!rst_b)
		upd_neg && upd_ovf && !wr_flags && alu_req.byte_op |=>
		neg_r == $past(calc_res[`CSF_MSB_BYTE]) &&
		ovf_r == $past(alu_req.op_a[`CSF_MSB_BYTE] ==
		alu_req.op_b[`CSF_MSB_BYTE] && calc_res[`CSF_MSB_BYTE] !=
		alu_req.op_a[`CSF_MSB_BYTE]))
		else $error("sign flags wrong for byte op");

	// Sticky zero operations never set the zero flag
	a_zero_sticky: assert property ( // see [RULE9]
		@(posedge clk) disable iff (!rst_b)
		upd_zero && alu_req.zero_sticky && !zero_r && !wr_flags |=>
		!zero_r)
		else $error("sticky zero op set zero flag");

	// Word carry from the 17th sum bit
	a_carry_word: assert property ( // see [RULE10]
		@(posedge clk) disable iff (!rst_b)
		upd_carry && !alu_req.byte_op && !wr_flags |=>
		carry_r == $past(17'(alu_req.op_a) + 17'(alu_req.op_b)
		+ 17'(alu_req.carry_in) > 17'h0ffff))
		else $error("carry wrong for word op");

	// Reset clears the whole word
	a_reset_clear: assert property ( // see [RULE11]
		@(posedge clk)
		!rst_b |=> flags_word == `CSF_FLAGS_RST)
		else $error("flags word not cleared by reset");

	// Software write beats a concurrent ALU update
	a_sw_write_wins: assert property ( // see [RULE13]
		@(posedge clk) disable iff (!rst_b)
		wr_flags && alu_req.valid |=>
		carry_r == $past(bus.wdata[`CSF_BIT_CARRY]) &&
		hc_r == $past(bus.wdata[`CSF_BIT_HC]))
		else $error("ALU update overrode software write");

	// An untouched carry flag holds over an operation
	a_flag_unaffected: assert property ( // see [RULE13]
		@(posedge clk) disable iff (!rst_b)
		alu_req.valid && !alu_req.affect.carry && !wr_flags |=>
		$stable(carry_r))
		else $error("unaffected carry changed");

endmodule

// ===== tb/csf_core_model.sv
`timescale 1ns/1ps

module csf_core_model (
	// Clock
	input wire logic clk,
	// ALU and loop sequencer side
	output csf_pkg::csf_alu_req_t alu_req,
	output logic loop_start,
	output logic loop_done
);
	import csf_pkg::*;

	// Idle until the bench asks for traffic
	initial begin
		alu_req = '0;
		loop_start = 1'b0;
		loop_done = 1'b0;
	end

	// One operation for one cycle; operands turn to junk once released
	task automatic op(input logic bo, input logic zs, input logic [4:0] af,
		input logic ci, input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		alu_req <= {1'b1, bo, zs, af, ci, a, b};
		@(posedge clk);
		alu_req <= {1'b0, bo, zs, af, ci, ~a, ~b};
		#1;
	endtask

	// Start or end a repeat loop with a one-cycle pulse
	task automatic loop(input logic start);
		@(posedge clk);
		loop_start <= start;
		loop_done <= !start;
		@(posedge clk);
		loop_start <= 1'b0;
		loop_done <= 1'b0;
		#1;
	endtask
endmodule

// ===== tb/tb_cpu_status_flag_register.sv
`timescale 1ns/1ps
`include "csf_consts.svh"

module tb_cpu_status_flag_register;
	import csf_pkg::*;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	csf_bus_req_t bus = '0;
	csf_alu_req_t alu_req;
	logic [15:0] rd_data, alu_result, flags_word;
	logic [3:0] eff_priority;
	logic user_irq_off, irq, loop_start, loop_done;
	int n_errors = 0;
	int cmp_count = 0;

	// 200 MHz core clock
	always #2.5 clk = ~clk;

	csf_status_reg dut (
		.clk(clk),
		.rst_b(rst_b),
		.bus(bus),
		.rd_data(rd_data),
		.alu_req(alu_req),
		.alu_result(alu_result),
		.loop_start(loop_start),
		.loop_done(loop_done),
		.flags_word(flags_word),
		.eff_priority(eff_priority),
		.user_irq_off(user_irq_off),
		.irq(irq)
	);

	csf_core_model core (
		.clk(clk),
		.alu_req(alu_req),
		.loop_start(loop_start),
		.loop_done(loop_done)
	);

	// Word and bit comparisons
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Register port cycles
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= {1'b1, 1'b0, a, d};
		@(posedge clk);
		bus.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk_word(rd_data, exp);
	endtask

	// Verdict and end of run
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (2000) @(posedge clk);
		n_errors++;
		test_done();
	end

	// Test sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(`CSF_ADDR_FLAGS, 16'h0000);
		rd(`CSF_ADDR_CTRL, 16'h0000);
		rd(4'hf, 16'h0000);
		chk_bit(irq, 1'b0);
		$display("test reset done");
		wr(`CSF_ADDR_FLAGS, 16'hffff);
		chk_word(flags_word, 16'h01ef);
		rd(`CSF_ADDR_FLAGS, 16'h01ef);
		rd(`CSF_ADDR_EVT_CLR, 16'h0000);
		chk_word({12'h000, eff_priority}, 16'h0007);
		chk_bit(user_irq_off, 1'b1);
		$display("test write mask done");
		wr(`CSF_ADDR_FLAGS, 16'h0000);
		core.op(1'b0, 1'b0, 5'h1f, 1'b0, 16'h7fff, 16'h0001);
		chk_word(flags_word, 16'h010c);
		chk_word(alu_result, 16'h8000);
		core.op(1'b0, 1'b0, 5'h1f, 1'b0, 16'hffff, 16'h0001);
		chk_word(flags_word, 16'h0103);
		core.op(1'b1, 1'b0, 5'h1f, 1'b0, 16'h127f, 16'h0001);
		chk_word(flags_word, 16'h010c);
		chk_word(alu_result, 16'h1280);
		core.op(1'b1, 1'b0, 5'h1f, 1'b0, 16'h12f0, 16'h0010);
		chk_word(flags_word, 16'h0003);
		core.op(1'b0, 1'b1, 5'h02, 1'b0, 16'h0000, 16'h0000);
		chk_word(flags_word, 16'h0003);
		core.op(1'b0, 1'b1, 5'h02, 1'b0, 16'h0005, 16'h0000);
		chk_word(flags_word, 16'h0001);
		core.op(1'b0, 1'b0, 5'h01, 1'b0, 16'h8000, 16'h0000);
		chk_word(flags_word, 16'h0000);
		core.op(1'b0, 1'b0, 5'h1f, 1'b1, 16'h0005, 16'hfffc);
		chk_word(flags_word, 16'h0101);
		chk_word(alu_result, 16'h0002);
		core.op(1'b0, 1'b1, 5'h02, 1'b0, 16'h0000, 16'h0000);
		chk_word(flags_word, 16'h0101);
		$display("test arithmetic done");
		fork
			core.op(1'b0, 1'b0, 5'h1f, 1'b0, 16'h7fff, 16'h0001);
			wr(`CSF_ADDR_FLAGS, 16'h0001);
		join
		chk_word(flags_word, 16'h0001);
		$display("test write priority done");
		wr(`CSF_ADDR_CTRL, 16'h0008);
		chk_word({12'h000, eff_priority}, 16'h0008);
		chk_bit(user_irq_off, 1'b1);
		wr(`CSF_ADDR_FLAGS, 16'h0060);
		chk_word({12'h000, eff_priority}, 16'h000b);
		wr(`CSF_ADDR_CTRL, 16'h8000);
		chk_bit(user_irq_off, 1'b0);
		wr(`CSF_ADDR_FLAGS, 16'h00e0);
		chk_word(flags_word, 16'h0060);
		rd(`CSF_ADDR_CTRL, 16'h8000);
		wr(`CSF_ADDR_CTRL, 16'h0000);
		wr(`CSF_ADDR_FLAGS, 16'h00e0);
		chk_word({12'h000, eff_priority}, 16'h0007);
		$display("test priority done");
		core.loop(1'b1);
		chk_word(flags_word, 16'h00f0);
		wr(`CSF_ADDR_FLAGS, 16'h0000);
		chk_word(flags_word, 16'h0010);
		core.loop(1'b0);
		chk_word(flags_word, 16'h0000);
		$display("test loop done");
		wr(`CSF_ADDR_EVT_CLR, 16'h0007);
		wr(`CSF_ADDR_EVT_EN, 16'h0001);
		rd(`CSF_ADDR_EVT_EN, 16'h0001);
		rd(`CSF_ADDR_EVT_STAT, 16'h0000);
		chk_bit(irq, 1'b0);
		core.op(1'b0, 1'b0, 5'h1f, 1'b0, 16'h7fff, 16'h0001);
		chk_bit(irq, 1'b1);
		rd(`CSF_ADDR_EVT_STAT, 16'h0001);
		wr(`CSF_ADDR_EVT_CLR, 16'h0001);
		chk_bit(irq, 1'b0);
		fork
			core.op(1'b0, 1'b0, 5'h1f, 1'b0, 16'h7fff, 16'h0001);
			wr(`CSF_ADDR_EVT_CLR, 16'h0001);
		join
		chk_bit(irq, 1'b1);
		wr(`CSF_ADDR_EVT_CLR, 16'h0001);
		chk_bit(irq, 1'b0);
		core.loop(1'b1);
		core.loop(1'b0);
		chk_bit(irq, 1'b0);
		rd(`CSF_ADDR_EVT_STAT, 16'h0002);
		wr(`CSF_ADDR_EVT_EN, 16'h0002);
		chk_bit(irq, 1'b1);
		wr(`CSF_ADDR_EVT_CLR, 16'h0002);
		chk_bit(irq, 1'b0);
		wr(`CSF_ADDR_FLAGS, 16'h00e0);
		chk_word(flags_word, 16'h00e0);
		rd(`CSF_ADDR_EVT_STAT, 16'h0004);
		chk_bit(irq, 1'b0);
		$display("test interrupt done");
		wr(`CSF_ADDR_FLAGS, 16'h01ff);
		chk_word(flags_word, 16'h01ef);
		wr(`CSF_ADDR_CTRL, 16'h8008);
		wr(`CSF_ADDR_EVT_EN, 16'h0007);
		chk_bit(irq, 1'b1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk_word(flags_word, 16'h0000);
		chk_word({12'h000, eff_priority}, 16'h0000);
		chk_bit(user_irq_off, 1'b0);
		chk_bit(irq, 1'b0);
		rd(`CSF_ADDR_CTRL, 16'h0000);
		rd(`CSF_ADDR_EVT_EN, 16'h0000);
		$display("test mid-run reset done");
		test_done();
	end
endmodule
